// ==== verif/rsb_pin_source.sv ====
// Partner model: external reset source that drives the active-low pin
`timescale 1ns/1ps
module rsb_pin_source (
	input  wire logic clk_in,      // System clock
	output logic      pin_n_out    // Reset pin level, pulled up when idle
);
	// Pin idles high because the board pull-up holds it there
	initial pin_n_out = 1'b1;

	// Pull the pin low for a number of clocks, changing just after edges
	task automatic hold_low(input int cycles);
		begin
			@(posedge clk_in);
			pin_n_out <= 1'b0;
			repeat (cycles) @(posedge clk_in);
			pin_n_out <= 1'b1;
		end
	endtask : hold_low
endmodule : rsb_pin_source

// ==== verif/rsb_reset_ctrl_test.sv ====
// Self-checking testbench for the reset source and boot select block
`timescale 1ns/1ps
module rsb_reset_ctrl_test;
	logic        clk_in;
	logic        rst_n_in;
	logic        brownout_in;
	logic        pin_reset_n_in;
	logic        watchdog_in;
	logic        power_down_in;
	logic [9:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        core_reset_out;
	logic        clk_restart_out;
	logic [15:0] pc_out;
	logic [7:0]  sp_out;
	logic        boot_loader_out;
	int          miscompares;
	int          n_checks;

	rsb_reset_ctrl i_dut (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .brownout_in(brownout_in),
		.pin_reset_n_in(pin_reset_n_in), .watchdog_in(watchdog_in),
		.power_down_in(power_down_in), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.core_reset_out(core_reset_out), .clk_restart_out(clk_restart_out),
		.pc_out(pc_out), .sp_out(sp_out), .boot_loader_out(boot_loader_out)
	);

	rsb_pin_source i_pin (
		.clk_in(clk_in),
		.pin_n_out(pin_reset_n_in)
	);

	// 100 MHz system clock
	initial
	begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	// Run is a few hundred cycles; a hang beyond this counts as failure
	initial
	begin
		#200000;
		miscompares++;
		tally_and_finish();
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		begin
			n_checks++;
			if (got !== exp)
			begin
				miscompares++;
				$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask : chk

	// One bus cycle; request held until waitrequest is sampled low on a rise
	task automatic bus(input logic wr, input logic [7:0] idx,
		input logic [7:0] wd, output logic [7:0] rd);
		int n;
		begin
			n = 0;
			@(posedge clk_in);
			avs_read      <= !wr;
			avs_write     <= wr;
			avs_address   <= {2'b00, idx};
			avs_writedata <= {24'h000000, wd};
			@(posedge clk_in);
			while (avs_waitrequest !== 1'b0 && n < 50)
			begin
				n++;
				@(posedge clk_in);
			end
			chk({31'h0, avs_waitrequest}, 32'h0);
			if (avs_waitrequest !== 1'b0)
				tally_and_finish();
			rd = avs_readdata[7:0];
			avs_read  <= 1'b0;
			avs_write <= 1'b0;
		end
	endtask : bus

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] dummy;
		begin
			bus(1'b1, idx, d, dummy);
		end
	endtask : wr

	// Read a register and compare the masked bits
	task automatic rd_chk(input logic [7:0] idx, input logic [7:0] mask,
		input logic [7:0] exp);
		logic [7:0] rd;
		begin
			bus(1'b0, idx, 8'h00, rd);
			chk({24'h0, rd & mask}, {24'h0, exp});
		end
	endtask : rd_chk

	// Unlock a protected register, then write it
	task automatic wr_prot(input logic [7:0] idx, input logic [7:0] d);
		begin
			wr(rsb_pkg::IDX_TIMED_ACCESS, rsb_pkg::TA_KEY_FIRST);
			wr(rsb_pkg::IDX_TIMED_ACCESS, rsb_pkg::TA_KEY_SECOND);
			wr(idx, d);
		end
	endtask : wr_prot

	// Bounded wait for the core reset level, then compare it
	task automatic wait_lvl(input logic lvl, input int max);
		int n;
		begin
			n = 0;
			@(negedge clk_in);
			while (core_reset_out !== lvl && n < max)
			begin
				n++;
				@(negedge clk_in);
			end
			chk({31'h0, core_reset_out}, {31'h0, lvl});
		end
	endtask : wait_lvl

	task automatic t_power_on;
		begin
			wait_lvl(1'b0, 5);
			chk({16'h0, pc_out}, {16'h0, rsb_pkg::RESET_VECTOR});
			chk({24'h0, sp_out}, {24'h0, rsb_pkg::STACK_RESET});
			chk({31'h0, boot_loader_out}, 32'h0);
			rd_chk(rsb_pkg::IDX_POWER_CTRL, 8'h10, 8'h10);
			rd_chk(rsb_pkg::IDX_AUX_CTRL, 8'hC0, 8'h00);
			rd_chk(rsb_pkg::IDX_BROWNOUT_CTRL, 8'h02, 8'h00);
			rd_chk(rsb_pkg::IDX_WATCHDOG_CTRL, 8'h08, 8'h00);
			rd_chk(rsb_pkg::IDX_BOOT_CONFIG, 8'hFF, 8'hFF);
		end
	endtask : t_power_on

	// Short pulse is ignored; a long one resets and reloads boot select
	task automatic t_pin;
		begin
			wr(rsb_pkg::IDX_POWER_CTRL, 8'h00);
			rd_chk(rsb_pkg::IDX_POWER_CTRL, 8'h10, 8'h00);
			i_pin.hold_low(10);
			rd_chk(rsb_pkg::IDX_AUX_CTRL, 8'h40, 8'h00);
			wr(rsb_pkg::IDX_BOOT_CONFIG, 8'h7F);
			fork
				i_pin.hold_low(40);
				begin
					wait_lvl(1'b1, 30);
					repeat (8) @(negedge clk_in);
					chk({31'h0, core_reset_out}, 32'h1);
				end
			join
			wait_lvl(1'b0, 5);
			chk({16'h0, pc_out}, 32'h0);
			rd_chk(rsb_pkg::IDX_AUX_CTRL, 8'h40, 8'h40);
			rd_chk(rsb_pkg::IDX_POWER_CTRL, 8'h10, 8'h00);
			rd_chk(rsb_pkg::IDX_CHIP_CTRL, 8'h02, 8'h02);
			chk({31'h0, boot_loader_out}, 32'h1);
		end
	endtask : t_pin

	task automatic t_wdog;
		begin
			@(posedge clk_in);
			watchdog_in <= 1'b1;
			@(posedge clk_in);
			watchdog_in <= 1'b0;
			wait_lvl(1'b1, 5);
			wait_lvl(1'b0, 5);
			rd_chk(rsb_pkg::IDX_WATCHDOG_CTRL, 8'h08, 8'h08);
			rd_chk(rsb_pkg::IDX_AUX_CTRL, 8'h40, 8'h40);
		end
	endtask : t_wdog

	// Locked request is refused; unlocked one resets and keeps boot select
	task automatic t_sw;
		begin
			wr(rsb_pkg::IDX_BOOT_CONFIG, 8'hFF);
			wr(rsb_pkg::IDX_CHIP_CTRL, 8'h82);
			repeat (4) @(negedge clk_in);
			chk({31'h0, core_reset_out}, 32'h0);
			wr_prot(rsb_pkg::IDX_CHIP_CTRL, 8'h82);
			wait_lvl(1'b1, 5);
			wait_lvl(1'b0, 5);
			rd_chk(rsb_pkg::IDX_CHIP_CTRL, 8'h82, 8'h02);
			chk({31'h0, boot_loader_out}, 32'h1);
			rd_chk(rsb_pkg::IDX_AUX_CTRL, 8'hC0, 8'hC0);
			rd_chk(rsb_pkg::IDX_WATCHDOG_CTRL, 8'h08, 8'h08);
		end
	endtask : t_sw

	task automatic t_bod;
		begin
			@(posedge clk_in);
			brownout_in <= 1'b1;
			repeat (5) @(negedge clk_in);
			chk({31'h0, core_reset_out}, 32'h0);
			@(posedge clk_in);
			brownout_in <= 1'b0;
			wr_prot(rsb_pkg::IDX_BROWNOUT_CTRL, 8'h04);
			@(posedge clk_in);
			brownout_in <= 1'b1;
			wait_lvl(1'b1, 5);
			@(posedge clk_in);
			brownout_in <= 1'b0;
			wait_lvl(1'b0, 10);
			rd_chk(rsb_pkg::IDX_BROWNOUT_CTRL, 8'h02, 8'h02);
			rd_chk(rsb_pkg::IDX_AUX_CTRL, 8'hC0, 8'hC0);
			rd_chk(rsb_pkg::IDX_POWER_CTRL, 8'h10, 8'h00);
			wr_prot(rsb_pkg::IDX_BROWNOUT_CTRL, 8'h00);
			rd_chk(rsb_pkg::IDX_BROWNOUT_CTRL, 8'h02, 8'h00);
		end
	endtask : t_bod

	// Pin low in power-down first restarts the clock, then resets
	task automatic t_pd;
		int n;
		int cnt;
		begin
			n = 0;
			cnt = 0;
			wr(rsb_pkg::IDX_AUX_CTRL, 8'h00);
			rd_chk(rsb_pkg::IDX_AUX_CTRL, 8'hC0, 8'h00);
			@(posedge clk_in);
			power_down_in <= 1'b1;
			fork
				i_pin.hold_low(60);
				begin
					@(negedge clk_in);
					while (clk_restart_out !== 1'b1 && n < 30)
					begin
						n++;
						@(negedge clk_in);
					end
					while (clk_restart_out === 1'b1 && cnt < 40)
					begin
						cnt++;
						@(negedge clk_in);
					end
					chk(cnt, rsb_pkg::CLK_SETTLE_CYC + 1);
					chk({31'h0, core_reset_out}, 32'h1);
					@(posedge clk_in);
					power_down_in <= 1'b0;
				end
			join
			wait_lvl(1'b0, 10);
			rd_chk(rsb_pkg::IDX_AUX_CTRL, 8'hC0, 8'h40);
		end
	endtask : t_pd

	task automatic t_misc;
		logic [7:0] rd;
		begin
			bus(1'b0, 8'h10, 8'h00, rd);
			chk(avs_readdata, 32'h0);
			@(posedge clk_in);
			rst_n_in <= 1'b0;
			repeat (4) @(posedge clk_in);
			rst_n_in <= 1'b1;
			wait_lvl(1'b0, 5);
			rd_chk(rsb_pkg::IDX_AUX_CTRL, 8'hC0, 8'h00);
			rd_chk(rsb_pkg::IDX_WATCHDOG_CTRL, 8'h08, 8'h00);
			rd_chk(rsb_pkg::IDX_POWER_CTRL, 8'h10, 8'h10);
		end
	endtask : t_misc

	task tally_and_finish;
		begin
			if (miscompares == 0 && n_checks > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask : tally_and_finish

	// Main sequence: power-on, then each reset source in turn
	initial
	begin
		miscompares    = 0;
		n_checks       = 0;
		rst_n_in       = 1'b0;
		brownout_in    = 1'b0;
		watchdog_in    = 1'b0;
		power_down_in  = 1'b0;
		avs_address    = 10'h000;
		avs_read       = 1'b0;
		avs_write      = 1'b0;
		avs_writedata  = 32'h0;
		avs_byteenable = 4'hF;
		repeat (16) @(posedge clk_in);
		rst_n_in <= 1'b1;
		t_power_on();
		t_pin();
		t_wdog();
		t_sw();
		t_bod();
		t_pd();
		t_misc();
		tally_and_finish();
	end
endmodule : rsb_reset_ctrl_test

// ==== verilog/rsb_flag.sv ====
// Sticky reset cause flag: set by its own reset, cleared by power-on
`timescale 1ns/1ps
module rsb_flag (
	input  wire logic clk_in,     // System clock
	input  wire logic rst_n_in,   // Async reset, active low
	input  wire logic por_in,     // Power-on pulse clears the flag
	input  wire logic set_in,     // Own reset source fired
	input  wire logic wr_in,      // Software write strobe
	input  wire logic wdata_in,   // Software write value
	output logic      flag_out    // Flag value
);
	logic flag_q;
	// Set wins over a same-cycle software clear
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			flag_q <= 1'b0;
		else if (set_in)
			flag_q <= 1'b1;
		else if (por_in)
			flag_q <= 1'b0;
		else if (wr_in)
			flag_q <= wdata_in;
	end
	assign flag_out = flag_q;
endmodule : rsb_flag

// ==== verilog/rsb_pin_filter.sv ====
// Pin reset qualifier: pin must stay low a minimum count of clocks
`timescale 1ns/1ps
module rsb_pin_filter (
	input  wire logic clk_in,      // System clock
	input  wire logic rst_n_in,    // Async reset, active low
	input  wire logic pin_n_in,    // Reset pin level, synchronous
	output logic      valid_out    // Pin held low long enough
);
	logic [4:0] cnt_q;
	// Count low cycles; saturate once qualified
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			cnt_q <= 5'h00;
		else if (pin_n_in)
			cnt_q <= 5'h00;
		else if (cnt_q != rsb_pkg::PIN_LOW_COUNT)
			cnt_q <= cnt_q + 5'h01;
	end
	assign valid_out = (cnt_q == rsb_pkg::PIN_LOW_COUNT);
endmodule : rsb_pin_filter

// ==== verilog/rsb_pkg.sv ====
// Package: register map, bit positions, reset values and timing for the reset block
package rsb_pkg;
	// Register indices (placed directly in the low byte of the bus address)
	localparam logic [7:0] IDX_POWER_CTRL    = 8'h87;
	localparam logic [7:0] IDX_CHIP_CTRL     = 8'h9F;
	localparam logic [7:0] IDX_AUX_CTRL      = 8'hA2;
	localparam logic [7:0] IDX_BROWNOUT_CTRL = 8'hA3;
	localparam logic [7:0] IDX_WATCHDOG_CTRL = 8'hAA;
	localparam logic [7:0] IDX_TIMED_ACCESS  = 8'hC7;
	localparam logic [7:0] IDX_BOOT_CONFIG   = 8'hC8;
	localparam logic [7:0] IDX_STATUS        = 8'hC9;
	// Field positions
	localparam int BIT_COLD_FLAG   = 4;
	localparam int BIT_BO_ENABLE   = 2;
	localparam int BIT_BO_FLAG     = 1;
	localparam int BIT_PIN_FLAG    = 6;
	localparam int BIT_SW_FLAG     = 7;
	localparam int BIT_WD_FLAG     = 3;
	localparam int BIT_SW_REQUEST  = 7;
	localparam int BIT_BOOT_SELECT = 1;
	localparam int BIT_CFG_BOOT    = 7;
	// Reset values
	localparam logic [7:0]  BOOT_CONFIG_RESET = 8'hFF;
	localparam logic [7:0]  BYTE_ZERO         = 8'h00;
	localparam logic [15:0] RESET_VECTOR      = 16'h0000;
	localparam logic [7:0]  STACK_RESET       = 8'h07;
	// Timed-access unlock pattern
	localparam logic [7:0] TA_KEY_FIRST  = 8'hAA;
	localparam logic [7:0] TA_KEY_SECOND = 8'h55;
	// Pin must stay low this many cycles to count as a reset
	localparam int          PIN_LOW_CYCLES = 24;
	localparam logic [4:0]  PIN_LOW_COUNT  = 5'(PIN_LOW_CYCLES);
	// Clock restart settle time out of power-down
	localparam int          CLK_PERIOD_NS    = 10;
	localparam int          CLK_SETTLE_NS    = 100;
	localparam int          CLK_SETTLE_CYC   =
		(CLK_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [4:0]  CLK_SETTLE_COUNT = 5'(CLK_SETTLE_CYC);
	// Sequencer states, one-hot
	typedef enum logic [3:0] {
		ST_RUN    = 4'h1,
		ST_WAKE   = 4'h2,
		ST_RESET  = 4'h4,
		ST_SOFTWARE_RESET_REQUEST  = 4'h8
	} rsb_state_t;
endpackage : rsb_pkg

// ==== verilog/rsb_reset_ctrl.sv ====
// Reset source merge, cause flags, boot select and Avalon-MM registers
// Behaviour
// - Five reset sources: power-on, brown-out, pin, watchdog, software.
// - Hold core in reset during power-on; start at 0000H afterwards.
// - Power-on reset sets the cold-reset flag, power control bit 4.
// - Other resets leave the cold-reset flag unchanged.
// - Brown-out resets the device when brown-out reset enable is one.
// - Brown-out reset sets brown-out flag; software may clear it.
// - Brown-out flag changes only by power-on, brown-out or write.
// - Pin reset applied synchronously to the system clock.
// - Stay in reset while pin low; restart at 0000H on release.
// - Pin low in power-down restarts clock; reset after it settles.
// - Pin reset sets pin-reset flag, aux register bit 6.
// - Pin flag changes only by power-on, pin reset or write.
// - Watchdog time-out resets system, resuming at 0000H.
// - Watchdog reset sets watchdog flag bit 3; limited changers.
// - Writing chip control bit 7 triggers software reset; self-clears.
// - The request-setting write is the last executed before reset.
// - Software reset sets software flag bit 7; limited changers.
// - Boot select zero fetches main block, one fetches boot loader.
// - Boot select loads inverted config bit 7 except on software reset.
// - Config bit one selects main block; config byte defaults all ones.
// - Reset forces program counter 0000H and stack pointer 07H.
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ps
module rsb_reset_ctrl (
	input  wire logic        clk_in,            // 100 MHz system clock
	input  wire logic        rst_n_in,          // Power-on reset, low
	input  wire logic        brownout_in,       // Supply below level
	input  wire logic        pin_reset_n_in,    // Reset pin, active low
	input  wire logic        watchdog_in,       // Watchdog time-out pulse
	input  wire logic        power_down_in,     // Core in power-down
	input  wire logic [9:0]  avs_address,       // Word address
	input  wire logic        avs_read,          // Read strobe
	input  wire logic        avs_write,         // Write strobe
	input  wire logic [31:0] avs_writedata,     // Write data
	input  wire logic [3:0]  avs_byteenable,    // Byte lanes
	output logic [31:0]      avs_readdata,      // Read data
	output logic             avs_waitrequest,   // Stall
	output logic             core_reset_out,    // Core held in reset
	output logic             clk_restart_out,   // Request clock restart
	output logic [15:0]      pc_out,            // Program counter load
	output logic [7:0]       sp_out,            // Stack pointer load
	output logic             boot_loader_out    // Fetch from loader block
);
	rsb_pkg::rsb_state_t state_q;
	rsb_pkg::rsb_state_t state_d;
	logic       por_q;          // First cycle after power-on
	logic       ack_q;          // Bus answer pending
	logic [7:0] power_ctrl_q;
	logic [7:0] boot_cfg_q;
	logic [7:0] chip_ctrl_q;    // Bit 7 request, bit 1 boot select
	logic       bo_enable_q;
	logic       ta_armed_q;     // Saw first key
	logic       ta_open_q;      // Next protected write allowed
	logic [4:0] settle_q;
	logic       pin_valid;
	logic       bo_rst;
	logic       wd_rst;
	logic       sw_req;
	logic       bo_flag;
	logic       pin_flag;
	logic       wd_flag;
	logic       sw_flag;
	logic       wr_en;
	logic [7:0] wbyte;
	logic [7:0] idx;
	logic       prot_ok;

	assign idx   = avs_address[7:0];
	assign wbyte = avs_writedata[7:0];
	// Low lane only; write lands on the edge where waitrequest is low
	assign wr_en = avs_write && ack_q && avs_byteenable[0];
	assign prot_ok = ta_open_q;

	// Reset causes
	assign bo_rst = brownout_in && bo_enable_q;
	assign wd_rst = watchdog_in;
	assign sw_req = chip_ctrl_q[rsb_pkg::BIT_SW_REQUEST];

	// Pin qualifier; pin is taken as synchronous to clk_in
	rsb_pin_filter u_pin (
		.clk_in    (clk_in),
		.rst_n_in  (rst_n_in),
		.pin_n_in  (pin_reset_n_in),
		.valid_out (pin_valid)
	);

	// Power-on marker: one cycle after reset release
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			por_q <= 1'b1;
		else
			por_q <= 1'b0;
	end

	// Sequencer state register
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			state_q <= rsb_pkg::ST_RESET;
		else
			state_q <= state_d;
	end

	// Next state: pin, watchdog, brown-out, software request
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			rsb_pkg::ST_RUN:
			begin
				if (!pin_reset_n_in && power_down_in)
					state_d = rsb_pkg::ST_WAKE;
				else if (pin_valid || bo_rst || wd_rst)
					state_d = rsb_pkg::ST_RESET;
				else if (sw_req)
					state_d = rsb_pkg::ST_SOFTWARE_RESET_REQUEST;
			end
			rsb_pkg::ST_WAKE:
			begin
				if (settle_q == rsb_pkg::CLK_SETTLE_COUNT)
					state_d = rsb_pkg::ST_RESET;
			end
			rsb_pkg::ST_RESET:
			begin
				if (pin_reset_n_in && !bo_rst && !wd_rst)
					state_d = rsb_pkg::ST_RUN;
			end
			rsb_pkg::ST_SOFTWARE_RESET_REQUEST:
				state_d = rsb_pkg::ST_RUN;
			default:
				state_d = rsb_pkg::ST_RESET;
		endcase
	end

	// Clock settle counter while waking from power-down
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			settle_q <= 5'h00;
		else if (state_q == rsb_pkg::ST_WAKE)
			settle_q <= settle_q + 5'h01;
		else
			settle_q <= 5'h00;
	end

	// Reset outputs: core held outside ST_RUN, clock restart requested in ST_WAKE
	always_comb
	begin
		core_reset_out  = (state_q != rsb_pkg::ST_RUN);
		clk_restart_out = (state_q == rsb_pkg::ST_WAKE);
	end

	// Vector and stack outputs from flops
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			pc_out <= rsb_pkg::RESET_VECTOR;
			sp_out <= rsb_pkg::STACK_RESET;
		end
		else
		begin
			pc_out <= rsb_pkg::RESET_VECTOR;
			sp_out <= rsb_pkg::STACK_RESET;
		end
	end

	// Timed-access unlock: AA then 55 opens one protected write
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			ta_armed_q <= 1'b0;
			ta_open_q  <= 1'b0;
		end
		else if (wr_en && idx == rsb_pkg::IDX_TIMED_ACCESS)
		begin
			ta_armed_q <= (wbyte == rsb_pkg::TA_KEY_FIRST);
			ta_open_q  <= ta_armed_q && (wbyte == rsb_pkg::TA_KEY_SECOND);
		end
		else if (wr_en)
		begin
			ta_armed_q <= 1'b0;
			ta_open_q  <= 1'b0;
		end
	end

	// Cold-reset flag register
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			power_ctrl_q <= rsb_pkg::BYTE_ZERO;
		else if (por_q)
			power_ctrl_q[rsb_pkg::BIT_COLD_FLAG] <= 1'b1;
		else if (wr_en && idx == rsb_pkg::IDX_POWER_CTRL)
			power_ctrl_q <= wbyte;
	end

	// Boot configuration byte, defaults to all ones
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			boot_cfg_q <= rsb_pkg::BOOT_CONFIG_RESET;
		else if (wr_en && idx == rsb_pkg::IDX_BOOT_CONFIG)
			boot_cfg_q <= wbyte;
	end

	// Chip control: software request and boot select
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			chip_ctrl_q <= rsb_pkg::BYTE_ZERO;
		else if (state_q == rsb_pkg::ST_SOFTWARE_RESET_REQUEST)
			chip_ctrl_q[rsb_pkg::BIT_SW_REQUEST] <= 1'b0;
		else if (por_q || state_q == rsb_pkg::ST_RESET)
		begin
			chip_ctrl_q[rsb_pkg::BIT_SW_REQUEST] <= 1'b0;
			chip_ctrl_q[rsb_pkg::BIT_BOOT_SELECT] <=
				~boot_cfg_q[rsb_pkg::BIT_CFG_BOOT];
		end
		else if (wr_en && idx == rsb_pkg::IDX_CHIP_CTRL && prot_ok)
			chip_ctrl_q <= wbyte;
	end

	// Brown-out reset enable
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			bo_enable_q <= 1'b0;
		else if (wr_en && idx == rsb_pkg::IDX_BROWNOUT_CTRL && prot_ok)
			bo_enable_q <= wbyte[rsb_pkg::BIT_BO_ENABLE];
	end

	// Fetch block after reset
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			boot_loader_out <= 1'b0;
		else
			boot_loader_out <= chip_ctrl_q[rsb_pkg::BIT_BOOT_SELECT];
	end

	// Sticky cause flags; power-on clears, own source sets
	rsb_flag u_bo_flag (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.por_in   (por_q),
		.set_in   (bo_rst && state_q == rsb_pkg::ST_RUN),
		.wr_in    (wr_en && idx == rsb_pkg::IDX_BROWNOUT_CTRL && prot_ok),
		.wdata_in (wbyte[rsb_pkg::BIT_BO_FLAG]),
		.flag_out (bo_flag)
	);
	rsb_flag u_pin_flag (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.por_in   (por_q),
		.set_in   ((pin_valid && state_q == rsb_pkg::ST_RUN) ||
			(state_q == rsb_pkg::ST_WAKE)),
		.wr_in    (wr_en && idx == rsb_pkg::IDX_AUX_CTRL),
		.wdata_in (wbyte[rsb_pkg::BIT_PIN_FLAG]),
		.flag_out (pin_flag)
	);
	rsb_flag u_wd_flag (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.por_in   (por_q),
		.set_in   (wd_rst && state_q == rsb_pkg::ST_RUN),
		.wr_in    (wr_en && idx == rsb_pkg::IDX_WATCHDOG_CTRL && prot_ok),
		.wdata_in (wbyte[rsb_pkg::BIT_WD_FLAG]),
		.flag_out (wd_flag)
	);
	rsb_flag u_sw_flag (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.por_in   (por_q),
		.set_in   (state_q == rsb_pkg::ST_SOFTWARE_RESET_REQUEST),
		.wr_in    (wr_en && idx == rsb_pkg::IDX_AUX_CTRL),
		.wdata_in (wbyte[rsb_pkg::BIT_SW_FLAG]),
		.flag_out (sw_flag)
	);

	// One wait cycle on every access, answer on the second edge
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			ack_q <= 1'b0;
		else
			ack_q <= (avs_read || avs_write) && !ack_q;
	end
	assign avs_waitrequest = (avs_read || avs_write) && !ack_q;

	// Read data registered; unmapped reads zero
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			avs_readdata <= 32'h0000_0000;
		else if (avs_read && !ack_q)
		begin
			avs_readdata <= 32'h0000_0000;
			case (idx)
				rsb_pkg::IDX_POWER_CTRL:
					avs_readdata[7:0] <= power_ctrl_q;
				rsb_pkg::IDX_CHIP_CTRL:
					avs_readdata[7:0] <= {1'b0, 5'h00,
						chip_ctrl_q[rsb_pkg::BIT_BOOT_SELECT],
						chip_ctrl_q[0]}; // Request bit is write-only
				rsb_pkg::IDX_AUX_CTRL:
					avs_readdata[7:0] <= {sw_flag, pin_flag, 6'h00};
				rsb_pkg::IDX_BROWNOUT_CTRL:
					avs_readdata[7:0] <= {5'h00, bo_enable_q, bo_flag, 1'b0};
				rsb_pkg::IDX_WATCHDOG_CTRL:
					avs_readdata[7:0] <= {4'h0, wd_flag, 3'h0};
				rsb_pkg::IDX_BOOT_CONFIG:
					avs_readdata[7:0] <= boot_cfg_q;
				rsb_pkg::IDX_STATUS:
					avs_readdata[7:0] <= {4'h0, state_q};
				default:
					avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	// Pin reset once the minimum low time is reached, outside power-down
	a_pin_qualify: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(state_q == rsb_pkg::ST_RUN && pin_valid && !power_down_in)
		|=> core_reset_out)
		else $error("pin reset not applied");
	a_pin_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(!pin_reset_n_in && state_q == rsb_pkg::ST_RESET)
		|=> core_reset_out)
		else $error("released while pin low");
	a_cold_flag: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$fell(por_q) |-> power_ctrl_q[rsb_pkg::BIT_COLD_FLAG])
		else $error("cold flag not set");
	a_por_clears: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$fell(por_q) |-> !sw_flag && !wd_flag)
		else $error("flags not cleared at power-on");
	a_bo_reset: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(state_q == rsb_pkg::ST_RUN && bo_rst)
		|=> core_reset_out && bo_flag)
		else $error("brown-out reset missed");
	a_wd_reset: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		(state_q == rsb_pkg::ST_RUN && wd_rst)
		|=> core_reset_out && wd_flag)
		else $error("watchdog reset missed");
	sequence s_sw_go;
		state_q == rsb_pkg::ST_SOFTWARE_RESET_REQUEST;
	endsequence
	a_sw_done: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		s_sw_go |=> sw_flag && !sw_req)
		else $error("software reset flag or clear wrong");
	a_sw_keeps_bs: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		s_sw_go |=> $stable(chip_ctrl_q[rsb_pkg::BIT_BOOT_SELECT]))
		else $error("boot select changed by software reset");
	a_wake_settle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(clk_restart_out) |-> ##[1:12] state_q == rsb_pkg::ST_RESET)
		else $error("wake did not reach reset");
endmodule : rsb_reset_ctrl
